// *** rtl/slrx_regs.sv ***
`timescale 1ns/1ps
// Contract
// - Upper reference byte comes from a read-write register resetting to zero.
// - Result bit reads 0 on match, 1 on mismatch of selected sample.
// - Each set lane invert bit inverts that logical lane's deserialized data.
// - Device identifier from lane 0 configuration captured in read-only register.
// - Bank identifier captured into low nibble of the bank register.
// - Adjust resolution captured into upper nibble; transmitter sends zero.
// - Adjust direction captured into bit 6 of lane identity; sent as zero.
// - Phase adjust request captured into bit 5 of lane identity; sent zero.
// - Lane identifier captured into bits 4:0; bit 7 reads zero.
// - Scrambling flag captured into bit 7; 1 means enabled.
// - Lane count minus one in 5-bit field; bits 6:5 read zero.
// - Octets per frame minus one in 8-bit field; only 0, 1, 3 sent.
// - Lower reference byte comes from its own read-write register.
// - A 2-bit channel select picks the converter under test.
// - A 2-bit sample select picks the sample within the frame.
// - Clear bit holds the result cleared; enable bit activates comparison.
module slrx_regs #(
    parameter int LANES = 8,
    parameter int LANE_W = 32,
    parameter int CHANNELS = 4,
    parameter int SAMPLES = 4
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire slrx_pkg::slrx_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic [LANES*LANE_W-1:0] lane_data_in,
    output logic [LANES*LANE_W-1:0] lane_data_out,
    input wire logic [CHANNELS*SAMPLES*slrx_pkg::SAMPLE_W-1:0] sample_data_in,
    input wire logic sample_valid_in,
    input wire logic link_params_valid_in,
    input wire slrx_pkg::slrx_link_params_t link_params_in,
    output logic [7:0] link_setup_out,
    output logic tpl_mismatch_flag_out
);
    import slrx_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] tpl_ctrl;
    logic [7:0] tpl_ref_low_byte;
    logic [7:0] tpl_ref_high_byte;
    logic tpl_mismatch_flag;
    logic [7:0] link_setup;
    logic [7:0] lane_polarity_flip;
    slrx_link_params_t rx_params;
    logic [7:0] rdata;
    logic rvalid;
    logic [LANES*LANE_W-1:0] lane_data;

    logic [7:0] next_tpl_ctrl;
    logic [7:0] next_tpl_ref_low_byte;
    logic [7:0] next_tpl_ref_high_byte;
    logic next_tpl_mismatch_flag;
    logic [7:0] next_link_setup;
    logic [7:0] next_lane_polarity_flip;
    slrx_link_params_t next_rx_params;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic [LANES*LANE_W-1:0] next_lane_data;

    logic [SEL_W-1:0] tpl_channel_select;
    logic [SEL_W-1:0] tpl_sample_select;
    logic [2*SEL_W-1:0] sample_index;
    logic [SAMPLE_W-1:0] picked_sample;
    logic [SAMPLE_W-1:0] tpl_reference;

    logic wr_ctrl;
    logic wr_ref_low;
    logic wr_ref_high;
    logic wr_setup;
    logic wr_invert;
    logic [7:0] rd_ctrl_byte;
    logic [7:0] rd_result_byte;
    logic [7:0] rd_bank_byte;
    logic [7:0] rd_lane_byte;
    logic [7:0] rd_scramble_byte;

    // ------------------------------------------------------------
    // Sample pick for the transport test
    // ------------------------------------------------------------
    always_comb begin
        tpl_channel_select = tpl_ctrl[TPL_CHAN_LSB +: SEL_W];
        tpl_sample_select = tpl_ctrl[TPL_SAMP_LSB +: SEL_W];
        sample_index = {tpl_channel_select, tpl_sample_select};
        picked_sample = sample_data_in[sample_index * SAMPLE_W +: SAMPLE_W];
    end

    // ------------------------------------------------------------
    // Test reference
    // ------------------------------------------------------------
    always_comb begin
        tpl_reference = {tpl_ref_high_byte, tpl_ref_low_byte};
    end

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    always_comb begin
        wr_ctrl = 1'b0;
        wr_ref_low = 1'b0;
        wr_ref_high = 1'b0;
        wr_setup = 1'b0;
        wr_invert = 1'b0;
        if (reg_req_in.wr) begin
            unique case (reg_req_in.addr)
                OFF_TPL_CTRL: wr_ctrl = 1'b1;
                OFF_TPL_REF_LOW: wr_ref_low = 1'b1;
                OFF_TPL_REF_HIGH: wr_ref_high = 1'b1;
                OFF_LINK_SETUP: wr_setup = 1'b1;
                OFF_LANE_INVERT: wr_invert = 1'b1;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Test control next values
    // ------------------------------------------------------------
    always_comb begin
        next_tpl_ctrl = tpl_ctrl;
        next_tpl_ref_low_byte = tpl_ref_low_byte;
        next_tpl_ref_high_byte = tpl_ref_high_byte;
        if (wr_ctrl) begin
            next_tpl_ctrl = reg_req_in.wdata;
        end
        if (wr_ref_low) begin
            next_tpl_ref_low_byte = reg_req_in.wdata;
        end
        if (wr_ref_high) begin
            next_tpl_ref_high_byte = reg_req_in.wdata;
        end
    end

    // ------------------------------------------------------------
    // Test control registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            tpl_ctrl <= RESET_BYTE;
            tpl_ref_low_byte <= RESET_BYTE;
            tpl_ref_high_byte <= RESET_BYTE;
        end else begin
            tpl_ctrl <= next_tpl_ctrl;
            tpl_ref_low_byte <= next_tpl_ref_low_byte;
            tpl_ref_high_byte <= next_tpl_ref_high_byte;
        end
    end

    // ------------------------------------------------------------
    // Link setup next values
    // ------------------------------------------------------------
    always_comb begin
        next_link_setup = link_setup;
        next_lane_polarity_flip = lane_polarity_flip;
        if (wr_setup) begin
            next_link_setup = reg_req_in.wdata;
        end
        if (wr_invert) begin
            next_lane_polarity_flip = reg_req_in.wdata;
        end
    end

    // ------------------------------------------------------------
    // Link setup registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            link_setup <= RESET_BYTE;
            lane_polarity_flip <= RESET_BYTE;
        end else begin
            link_setup <= next_link_setup;
            lane_polarity_flip <= next_lane_polarity_flip;
        end
    end

    // ------------------------------------------------------------
    // Test result next value
    // ------------------------------------------------------------
    always_comb begin
        next_tpl_mismatch_flag = tpl_mismatch_flag;
        if (tpl_ctrl[TPL_CLR_BIT]) begin
            next_tpl_mismatch_flag = 1'b0;
        end else if (tpl_ctrl[TPL_EN_BIT] && sample_valid_in) begin
            next_tpl_mismatch_flag = (picked_sample != tpl_reference);
        end
    end

    // ------------------------------------------------------------
    // Test result register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            tpl_mismatch_flag <= 1'b0;
        end else begin
            tpl_mismatch_flag <= next_tpl_mismatch_flag;
        end
    end

    // ------------------------------------------------------------
    // Captured link parameters
    // ------------------------------------------------------------
    always_comb begin
        next_rx_params = rx_params;
        if (link_params_valid_in) begin
            next_rx_params = link_params_in;
        end
    end

    // ------------------------------------------------------------
    // Lane inversion
    // ------------------------------------------------------------
    always_comb begin
        next_lane_data = lane_data_in;
        for (int i = 0; i < LANES; i++) begin
            if (i < 8 && lane_polarity_flip[i]) begin
                next_lane_data[i*LANE_W +: LANE_W] = ~lane_data_in[i*LANE_W +: LANE_W];
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        next_rvalid = reg_req_in.rd;
        next_rdata = READ_ZERO;
        if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                OFF_TPL_CTRL: next_rdata = rd_ctrl_byte;
                OFF_TPL_REF_LOW: next_rdata = tpl_ref_low_byte;
                OFF_TPL_REF_HIGH: next_rdata = tpl_ref_high_byte;
                OFF_TPL_RESULT: next_rdata = rd_result_byte;
                OFF_LINK_SETUP: next_rdata = link_setup;
                OFF_LANE_INVERT: next_rdata = lane_polarity_flip;
                OFF_RX_DEVICE_ID: next_rdata = rx_params.device_id;
                OFF_RX_BANK_ADJUST: next_rdata = rd_bank_byte;
                OFF_RX_LANE_IDENTITY: next_rdata = rd_lane_byte;
                OFF_RX_SCRAMBLE_LANES: next_rdata = rd_scramble_byte;
                OFF_RX_OCTETS_FRAME: next_rdata = rx_params.octets_minus1;
                default: next_rdata = READ_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read byte assembly
    // ------------------------------------------------------------
    always_comb begin
        rd_ctrl_byte = {2'h0, tpl_ctrl[5:0]};
        rd_result_byte = {7'h00, tpl_mismatch_flag};
        rd_bank_byte = {rx_params.adjust_resolution, rx_params.bank_id};
        rd_lane_byte = {1'b0, rx_params.adjust_direction, rx_params.phase_adjust_request,
            rx_params.lane_id};
        rd_scramble_byte = {rx_params.scramble, 2'h0, rx_params.lanes_minus1};
    end

    // ------------------------------------------------------------
    // Read registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rdata <= RESET_BYTE;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // ------------------------------------------------------------
    // Captured link parameter registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rx_params <= '0;
        end else begin
            rx_params <= next_rx_params;
        end
    end

    // ------------------------------------------------------------
    // Lane data registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            lane_data <= '0;
        end else begin
            lane_data <= next_lane_data;
        end
    end

    assign reg_rdata_out = rdata;
    assign reg_rvalid_out = rvalid;
    assign lane_data_out = lane_data;
    assign link_setup_out = link_setup;
    assign tpl_mismatch_flag_out = tpl_mismatch_flag;

endmodule : slrx_regs

// *** rtl/slrx_pkg.sv ***
package slrx_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_TPL_CTRL = 12'h32C;
    localparam logic [11:0] OFF_TPL_REF_LOW = 12'h32D;
    localparam logic [11:0] OFF_TPL_REF_HIGH = 12'h32E;
    localparam logic [11:0] OFF_TPL_RESULT = 12'h32F;
    localparam logic [11:0] OFF_LINK_SETUP = 12'h333;
    localparam logic [11:0] OFF_LANE_INVERT = 12'h334;
    localparam logic [11:0] OFF_RX_DEVICE_ID = 12'h400;
    localparam logic [11:0] OFF_RX_BANK_ADJUST = 12'h401;
    localparam logic [11:0] OFF_RX_LANE_IDENTITY = 12'h402;
    localparam logic [11:0] OFF_RX_SCRAMBLE_LANES = 12'h403;
    localparam logic [11:0] OFF_RX_OCTETS_FRAME = 12'h404;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int TPL_EN_BIT = 0;
    localparam int TPL_CLR_BIT = 1;
    localparam int TPL_CHAN_LSB = 2;
    localparam int TPL_SAMP_LSB = 4;
    localparam int SEL_W = 2;
    localparam int SAMPLE_W = 16;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } slrx_reg_req_t;

    typedef struct packed {
        logic [7:0] device_id;
        logic [3:0] adjust_resolution;
        logic [3:0] bank_id;
        logic adjust_direction;
        logic phase_adjust_request;
        logic [4:0] lane_id;
        logic scramble;
        logic [4:0] lanes_minus1;
        logic [7:0] octets_minus1;
    } slrx_link_params_t;

endpackage : slrx_pkg

// *** testbench/slrx_sva.sv ***
`timescale 1ns/1ps
module slrx_sva #(
    parameter int LANES = 8,
    parameter int LANE_W = 32
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire slrx_pkg::slrx_reg_req_t reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic [LANES*LANE_W-1:0] lane_data_in,
    input wire logic [LANES*LANE_W-1:0] lane_data_out,
    input wire logic link_params_valid_in,
    input wire slrx_pkg::slrx_link_params_t link_params_in,
    input wire logic [7:0] link_setup_out,
    input wire logic tpl_mismatch_flag_out
);
    import slrx_pkg::*;
    // ----------
    // Checks
    // ----------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic rd;
    logic wr;
    logic [11:0] a;
    assign rd = reg_req_in.rd;
    assign wr = reg_req_in.wr;
    assign a = reg_req_in.addr;
    read_answer_a: assert property (rd |=> reg_rvalid_out) else $error("no read answer");
    answer_cause_a: assert property (reg_rvalid_out |-> $past(rd)) else $error("stray rvalid");
    idle_zero_a: assert property (!reg_rvalid_out |-> reg_rdata_out == 8'h00)
        else $error("rdata not zero");
    setup_follow_a: assert property (wr && a == OFF_LINK_SETUP |=>
        link_setup_out == $past(reg_req_in.wdata)) else $error("setup byte");
    result_read_a: assert property (rd && a == OFF_TPL_RESULT |=>
        reg_rdata_out == {7'h00, $past(tpl_mismatch_flag_out)}) else $error("result read");
    clear_hold_a: assert property (wr && a == OFF_TPL_CTRL && reg_req_in.wdata[1] |->
        ##2 !tpl_mismatch_flag_out) else $error("clear ignored");
    invert_all_a: assert property (wr && a == OFF_LANE_INVERT && reg_req_in.wdata == 8'hFF
        ##1 !(wr && a == OFF_LANE_INVERT) |-> ##1 lane_data_out == ~$past(lane_data_in))
        else $error("lane invert");
    param_load_a: assert property (link_params_valid_in
        ##1 (rd && a == OFF_RX_DEVICE_ID) |=>
        reg_rdata_out == $past(link_params_in.device_id, 2)) else $error("device id");
    lid_resv_a: assert property (rd && a == OFF_RX_LANE_IDENTITY |=> !reg_rdata_out[7])
        else $error("reserved bit");
endmodule : slrx_sva
bind slrx_regs slrx_sva #(.LANES(LANES), .LANE_W(LANE_W)) u_slrx_sva (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .lane_data_in(lane_data_in), .lane_data_out(lane_data_out),
    .link_params_valid_in(link_params_valid_in), .link_params_in(link_params_in),
    .link_setup_out(link_setup_out), .tpl_mismatch_flag_out(tpl_mismatch_flag_out));

// *** testbench/slrx_tx_model.sv ***
`timescale 1ns/1ps
module slrx_tx_model (
    input wire logic ref_clk_in,
    output logic [255:0] lane_data_out,
    output logic [255:0] sample_data_out,
    output logic sample_valid_out,
    output logic params_valid_out,
    output slrx_pkg::slrx_link_params_t params_out
);
    import slrx_pkg::*;
    // ----------
    // Lanes and samples
    // ----------
    logic [31:0] ctr;
    initial begin
        ctr = 32'h1;
        params_valid_out = 1'b0;
        params_out = '0;
        sample_valid_out = 1'b1;
        lane_data_out = '0;
        for (int k = 0; k < 16; k++) sample_data_out[k*16 +: 16] = 16'h3C00 ^ (16'h0111 * 16'(k));
    end
    always @(negedge ref_clk_in) begin
        ctr <= ctr * 32'h0019660D + 32'h3C6EF35F;
        for (int i = 0; i < 8; i++) lane_data_out[i*32 +: 32] <= ctr ^ (32'h11111111 * 32'(i));
    end
    task automatic send_cfg(input slrx_link_params_t p);
        slrx_link_params_t q;
        q = p;
        q.adjust_resolution = 4'h0;
        q.adjust_direction = 1'b0;
        q.phase_adjust_request = 1'b0;
        if (p.octets_minus1 != 8'h03) q.octets_minus1 = {7'h00, p.octets_minus1[0]};
        @(negedge ref_clk_in);
        params_out <= q;
        params_valid_out <= 1'b1;
        @(negedge ref_clk_in);
        params_valid_out <= 1'b0;
        params_out <= ~q;
    endtask : send_cfg
    task automatic set_valid(input logic v);
        @(negedge ref_clk_in);
        sample_valid_out <= v;
    endtask : set_valid
endmodule : slrx_tx_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`define CHK(w, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %s exp %0h got %0h", w, e, g); end end
module tb;
    import slrx_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    slrx_reg_req_t req = '0;
    logic [7:0] rdata, setup;
    logic rvalid, flag, svld, pvld;
    logic [255:0] lin, lout, smp, exp_l;
    slrx_link_params_t par, p;
    int err_count = 0, checked = 0, cyc = 0;
    logic [15:0] v;
    slrx_regs u_slrx_regs (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .lane_data_in(lin), .lane_data_out(lout),
        .sample_data_in(smp), .sample_valid_in(svld), .link_params_valid_in(pvld),
        .link_params_in(par), .link_setup_out(setup), .tpl_mismatch_flag_out(flag));
    slrx_tx_model u_slrx_tx_model (.ref_clk_in(ref_clk_in), .lane_data_out(lin),
        .sample_data_out(smp), .sample_valid_out(svld), .params_valid_out(pvld), .params_out(par));
    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk_in);
        req = '0;
    endtask : bus_wr
    task automatic bus_rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge ref_clk_in);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge ref_clk_in);
        req = '0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
    endtask : bus_rd
    // ----------
    // Scenarios
    // ----------
    task automatic t_basic();
        logic [11:0] offs [12] = '{OFF_TPL_CTRL, OFF_TPL_REF_LOW, OFF_TPL_REF_HIGH, OFF_TPL_RESULT,
            OFF_LINK_SETUP, OFF_LANE_INVERT, OFF_RX_DEVICE_ID, OFF_RX_BANK_ADJUST,
            OFF_RX_LANE_IDENTITY, OFF_RX_SCRAMBLE_LANES, OFF_RX_OCTETS_FRAME, 12'h7FF};
        foreach (offs[i]) bus_rd(offs[i], 8'h00);
        bus_wr(OFF_TPL_REF_HIGH, 8'hA7);
        bus_wr(OFF_TPL_REF_LOW, 8'h4C);
        bus_wr(OFF_LINK_SETUP, 8'h01);
        bus_wr(OFF_RX_DEVICE_ID, 8'hFF);
        bus_rd(OFF_TPL_REF_HIGH, 8'hA7);
        bus_rd(OFF_TPL_REF_LOW, 8'h4C);
        bus_rd(OFF_LINK_SETUP, 8'h01);
        `CHK("setup", 8'h01, setup)
        bus_rd(OFF_RX_DEVICE_ID, 8'h00);
    endtask : t_basic
    task automatic t_tpl();
        for (int k = 0; k < 16; k++) begin
            v = 16'h3C00 ^ (16'h0111 * 16'(k));
            bus_wr(OFF_TPL_REF_LOW, v[7:0]);
            bus_wr(OFF_TPL_REF_HIGH, v[15:8]);
            bus_wr(OFF_TPL_CTRL, {2'b00, 2'(k % 4), 2'(k / 4), 2'b01});
            bus_rd(OFF_TPL_RESULT, 8'h00);
            bus_wr(OFF_TPL_REF_HIGH, v[15:8] ^ 8'h80);
            bus_rd(OFF_TPL_RESULT, 8'h01);
            `CHK("flag", 1'b1, flag)
        end
        u_slrx_tx_model.set_valid(1'b0);
        bus_wr(OFF_TPL_REF_HIGH, v[15:8]);
        bus_rd(OFF_TPL_RESULT, 8'h01);
        u_slrx_tx_model.set_valid(1'b1);
        bus_rd(OFF_TPL_RESULT, 8'h00);
        `CHK("flag", 1'b0, flag)
        bus_wr(OFF_TPL_REF_HIGH, v[15:8] ^ 8'h80);
        bus_wr(OFF_TPL_CTRL, 8'h3C);
        bus_wr(OFF_TPL_REF_HIGH, v[15:8]);
        bus_rd(OFF_TPL_RESULT, 8'h01);
        bus_wr(OFF_TPL_CTRL, 8'h3F);
        bus_rd(OFF_TPL_RESULT, 8'h00);
    endtask : t_tpl
    task automatic t_params();
        for (int o = 0; o < 4; o++) begin
            if (o == 2) continue;
            p = '{device_id: 8'h96 ^ 8'(o), adjust_resolution: 4'h0, bank_id: 4'h9 ^ 4'(o),
                adjust_direction: 1'b0, phase_adjust_request: 1'b0, lane_id: 5'h15 ^ 5'(o),
                scramble: 1'(o), lanes_minus1: 5'(o), octets_minus1: 8'(o)};
            fork
                u_slrx_tx_model.send_cfg(p);
                begin
                    @(negedge ref_clk_in);
                    bus_rd(OFF_RX_DEVICE_ID, p.device_id);
                end
            join
            bus_rd(OFF_RX_BANK_ADJUST, {p.adjust_resolution, p.bank_id});
            bus_rd(OFF_RX_LANE_IDENTITY, {1'b0, 2'b00, p.lane_id});
            bus_rd(OFF_RX_SCRAMBLE_LANES, {p.scramble, 2'b00, p.lanes_minus1});
            bus_rd(OFF_RX_OCTETS_FRAME, p.octets_minus1);
        end
        bus_wr(OFF_RX_OCTETS_FRAME, 8'h55);
        bus_rd(OFF_RX_OCTETS_FRAME, 8'h03);
    endtask : t_params
    task automatic t_lanes();
        logic [7:0] m [3] = '{8'hFF, 8'h5A, 8'h00};
        foreach (m[j]) begin
            bus_wr(OFF_LANE_INVERT, m[j]);
            bus_rd(OFF_LANE_INVERT, m[j]);
            repeat (3) begin
                @(negedge ref_clk_in);
                for (int i = 0; i < 256; i++) exp_l[i] = lin[i] ^ m[j][i / 32];
                `CHK("lanes", exp_l, lout)
            end
        end
    endtask : t_lanes
    initial begin
        repeat (20) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        t_basic();
        t_tpl();
        t_params();
        t_lanes();
        close_out();
    end
endmodule : tb
